// ---- pkg/tpg_pkg.sv ----
// Constants, field layout and types shared by the test pattern generator
package tpg_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WIDTH = 8'h04;
  localparam logic [7:0] REG_HEIGHT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // Field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_W = 3;
  localparam int CTRL_EXT_BIT = 3;
  localparam int CTRL_ACQ_BIT = 4;
  localparam int STAT_FCNT_LSB = 0;
  localparam int STAT_BUSY_BIT = 16;
  localparam int STAT_BYPASS_BIT = 17;

  // Widths of pixel data and the frame counter
  localparam int PIX_W = 12;
  localparam int FCNT_W = 12;
  localparam int NARROW_W = 8;

  // Reset values
  localparam logic [15:0] WIDTH_RST = 16'h0800;
  localparam logic [15:0] HEIGHT_RST = 16'h0400;
  localparam logic EXT_RST = 1'b0;
  localparam logic ACQ_RST = 1'b0;
  localparam logic [FCNT_W-1:0] FCNT_RST = 12'h000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // Pattern selection codes
  typedef enum logic [2:0] {
    PATTERN_SELECT_OFF = 3'b000,
    PATTERN_SELECT_FIRST = 3'b001,
    PATTERN_SELECT_MOV8 = 3'b010,
    PATTERN_SELECT_MOV12 = 3'b011,
    PATTERN_SELECT_FT8 = 3'b100,
    PATTERN_SELECT_FT12 = 3'b101
  } tpg_pat_e;

  // Line builder states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_LINE = 2'b01,
    ST_LINE = 2'b10
  } tpg_state_e;

endpackage

// ---- src/tpg_gradient.sv ----
// Diagonal gradient value for one pixel
`timescale 1ns/1ps
`default_nettype none

module tpg_gradient
  import tpg_pkg::*;
#(
  parameter int DIM_W = 16
) (
  // Pixel position and frame count
  input wire logic [DIM_W-1:0] col,
  input wire logic [DIM_W-1:0] row,
  input wire logic [FCNT_W-1:0] fcnt,
  // Pattern of the current frame
  input wire tpg_pat_e sel,
  // Gray value
  output logic [PIX_W-1:0] value
);

  logic moving;
  logic [PIX_W-1:0] sum;

  // Moving patterns add the frame count, fixed one does not
  assign moving = (sel != PATTERN_SELECT_FIRST); // RULE9
  // Truncation to twelve bits is the modulo 4096
  assign sum = col[PIX_W-1:0] + row[PIX_W-1:0] + (moving ? fcnt : FCNT_RST); // RULE11 RULE13

  // Eight-bit patterns keep only the low byte
  always_comb begin
    unique case (sel)
      PATTERN_SELECT_MOV12, PATTERN_SELECT_FT12: value = sum; // RULE11 RULE13
      default: value = {{(PIX_W-NARROW_W){1'b0}}, sum[NARROW_W-1:0]}; // RULE8 RULE10 RULE12
    endcase
  end

endmodule

`default_nettype wire

// ---- src/tpg_top.sv ----
// Function
// RULE1 - Test mode ignores sensor data, builds lines
// RULE2 - Finished test frame goes out normal path
// RULE3 - Frame size follows geometry settings
// RULE4 - External triggers still needed in test mode
// RULE5 - Analog settings never alter test pixels
// RULE6 - Patterns 1-3 bypass processing, 4-5 not
// RULE7 - Selector picks one pattern or off
// RULE8 - Pattern 1: column plus row mod 256
// RULE9 - Frame counter advances each new frame
// RULE10 - Pattern 2: col+row+counter mod 256
// RULE11 - Pattern 3: col+row+counter mod 4096
// RULE12 - Pattern 4 like 2, through processing
// RULE13 - Pattern 5 like 3, through processing
// RULE14 - Column and row start at zero
// RULE15 - Frame counter resets zero, wraps naturally
`timescale 1ns/1ps
`default_nettype none

module tpg_top
  import tpg_pkg::*;
#(
  parameter int DIM_W = 16,
  parameter int AXI_AW = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Trigger pins
  input wire logic frame_trig_pin,
  input wire logic line_trig_pin,
  // Sensor and converter stream
  input wire logic sens_valid,
  input wire logic [PIX_W-1:0] sens_data,
  input wire logic sens_sol,
  input wire logic sens_sof,
  input wire logic sens_eol,
  input wire logic sens_eof,
  // Stream toward frame memory
  output logic pix_valid,
  output logic [PIX_W-1:0] pix_data,
  output logic pix_sol,
  output logic pix_sof,
  output logic pix_eol,
  output logic pix_eof,
  output logic pix_bypass,
  output logic pix_test,
  // Frame complete, starts transmission
  output logic frame_done
);

  // Register contents
  tpg_pat_e sel_r;
  logic ext_trig_r;
  logic acq_en_r;
  logic [DIM_W-1:0] width_r;
  logic [DIM_W-1:0] height_r;

  // AXI channel state
  logic aw_ready_r;
  logic w_ready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [AXI_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic ar_ready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic [31:0] width_m;
  logic [31:0] height_m;

  // Trigger synchronisers and edge detection
  logic [1:0] ftrig_sync_r;
  logic [1:0] ltrig_sync_r;
  logic ftrig_prev_r;
  logic ltrig_prev_r;
  logic ftrig_rise;
  logic ltrig_rise;

  // Line builder
  tpg_state_e st_r;
  tpg_pat_e frame_sel_r;
  logic [DIM_W-1:0] col_r;
  logic [DIM_W-1:0] row_r;
  logic [FCNT_W-1:0] fcnt_r;
  logic frame_start;
  logic line_start;
  logic last_col;
  logic last_row;
  logic [PIX_W-1:0] gen_val;
  logic gen_busy;
  logic test_mode;

  // Output flops
  logic pix_valid_r;
  logic [PIX_W-1:0] pix_data_r;
  logic pix_sol_r;
  logic pix_sof_r;
  logic pix_eol_r;
  logic pix_eof_r;
  logic pix_bypass_r;
  logic pix_test_r;
  logic frame_done_r;

  // Replace only the bytes whose strobe is set
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Codes with no pattern behind them fall back to off
  function automatic tpg_pat_e to_pattern(input logic [CTRL_SEL_W-1:0] code);
    tpg_pat_e p;
    unique case (code)
      3'h1: p = PATTERN_SELECT_FIRST;
      3'h2: p = PATTERN_SELECT_MOV8;
      3'h3: p = PATTERN_SELECT_MOV12;
      3'h4: p = PATTERN_SELECT_FT8;
      3'h5: p = PATTERN_SELECT_FT12;
      default: p = PATTERN_SELECT_OFF;
    endcase
    return p;
  endfunction

  // Write address channel, held until the response is taken
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_ready_r <= 1'b1;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && aw_ready_r) begin
      aw_ready_r <= 1'b0;
      aw_addr_r <= s_axi_awaddr;
    end else if (bvalid_r && s_axi_bready) begin
      aw_ready_r <= 1'b1;
    end
  end

  // Write data channel, either order against the address
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      w_ready_r <= 1'b1;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && w_ready_r) begin
      w_ready_r <= 1'b0;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (bvalid_r && s_axi_bready) begin
      w_ready_r <= 1'b1;
    end
  end

  assign do_write = !aw_ready_r && !w_ready_r && !bvalid_r;

  // Write response one cycle after both halves are held
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= (aw_addr_r[7:2] == REG_CTRL[7:2] || aw_addr_r[7:2] == REG_WIDTH[7:2] ||
                  aw_addr_r[7:2] == REG_HEIGHT[7:2] || aw_addr_r[7:2] == REG_STATUS[7:2]) ?
                 RESP_OKAY : RESP_DECERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Control register; selector takes a pattern or off
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_r <= PATTERN_SELECT_OFF;
      ext_trig_r <= EXT_RST;
      acq_en_r <= ACQ_RST;
    end else if (do_write && aw_addr_r[7:2] == REG_CTRL[7:2] && w_strb_r[0]) begin
      sel_r <= to_pattern(w_data_r[CTRL_SEL_LSB +: CTRL_SEL_W]); // RULE7
      ext_trig_r <= w_data_r[CTRL_EXT_BIT];
      acq_en_r <= w_data_r[CTRL_ACQ_BIT];
    end
  end

  // Byte-merged geometry words, ready for a pending write
  assign width_m = merge_bytes({{(32-DIM_W){1'b0}}, width_r}, w_data_r, w_strb_r);
  assign height_m = merge_bytes({{(32-DIM_W){1'b0}}, height_r}, w_data_r, w_strb_r);

  // Frame geometry; zero would stall a frame, so it is held at one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      width_r <= WIDTH_RST[DIM_W-1:0];
      height_r <= HEIGHT_RST[DIM_W-1:0];
    end else if (do_write && aw_addr_r[7:2] == REG_WIDTH[7:2]) begin
      width_r <= (width_m[DIM_W-1:0] == '0) ? DIM_W'(1) : width_m[DIM_W-1:0]; // RULE3
    end else if (do_write && aw_addr_r[7:2] == REG_HEIGHT[7:2]) begin
      height_r <= (height_m[DIM_W-1:0] == '0) ? DIM_W'(1) : height_m[DIM_W-1:0]; // RULE3
    end
  end

  // Read channel, data one cycle after the address
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ar_ready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && ar_ready_r) begin
      ar_ready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      unique case (s_axi_araddr[7:2])
        REG_CTRL[7:2]: begin
          rdata_r[CTRL_SEL_LSB +: CTRL_SEL_W] <= sel_r;
          rdata_r[CTRL_EXT_BIT] <= ext_trig_r;
          rdata_r[CTRL_ACQ_BIT] <= acq_en_r;
        end
        REG_WIDTH[7:2]: rdata_r[DIM_W-1:0] <= width_r;
        REG_HEIGHT[7:2]: rdata_r[DIM_W-1:0] <= height_r;
        REG_STATUS[7:2]: begin
          rdata_r[STAT_FCNT_LSB +: FCNT_W] <= fcnt_r;
          rdata_r[STAT_BUSY_BIT] <= gen_busy;
          rdata_r[STAT_BYPASS_BIT] <= pix_bypass_r;
        end
        default: rresp_r <= RESP_DECERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      ar_ready_r <= 1'b1;
    end
  end

  // Trigger pins cross in through two flops each
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ftrig_sync_r <= 2'b00;
      ltrig_sync_r <= 2'b00;
      ftrig_prev_r <= 1'b0;
      ltrig_prev_r <= 1'b0;
    end else begin
      ftrig_sync_r <= {ftrig_sync_r[0], frame_trig_pin};
      ltrig_sync_r <= {ltrig_sync_r[0], line_trig_pin};
      ftrig_prev_r <= ftrig_sync_r[1];
      ltrig_prev_r <= ltrig_sync_r[1];
    end
  end

  assign ftrig_rise = ftrig_sync_r[1] && !ftrig_prev_r;
  assign ltrig_rise = ltrig_sync_r[1] && !ltrig_prev_r;

  // External mode waits on the pins; a missed edge is a missed frame
  assign frame_start = ext_trig_r ? ftrig_rise : 1'b1; // RULE4
  assign line_start = ext_trig_r ? ltrig_rise : 1'b1; // RULE4
  assign last_col = (col_r == width_r - DIM_W'(1)); // RULE3
  assign last_row = (row_r == height_r - DIM_W'(1)); // RULE3
  assign gen_busy = (st_r != ST_IDLE);
  assign test_mode = gen_busy || (sel_r != PATTERN_SELECT_OFF); // RULE1

  // Frame and line sequencing; pattern is latched per frame
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      frame_sel_r <= PATTERN_SELECT_OFF;
      col_r <= '0;
      row_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (sel_r != PATTERN_SELECT_OFF && acq_en_r && frame_start) begin
            st_r <= ST_WAIT_LINE;
            frame_sel_r <= sel_r;
            row_r <= '0; // RULE14
          end
        end
        ST_WAIT_LINE: begin
          if (line_start) begin
            st_r <= ST_LINE;
            col_r <= '0; // RULE14
          end
        end
        ST_LINE: begin
          if (last_col) begin
            col_r <= '0;
            if (last_row) begin
              st_r <= ST_IDLE;
            end else begin
              row_r <= row_r + DIM_W'(1); // RULE14
              st_r <= ST_WAIT_LINE;
            end
          end else begin
            col_r <= col_r + DIM_W'(1); // RULE14
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Frame counter bumps at each test frame start and wraps freely
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fcnt_r <= FCNT_RST; // RULE15
    end else if (st_r == ST_IDLE && sel_r != PATTERN_SELECT_OFF && acq_en_r && frame_start) begin
      fcnt_r <= fcnt_r + FCNT_W'(1); // RULE9 RULE15
    end
  end

  // Gradient arithmetic for the current pixel
  tpg_gradient #(
    .DIM_W(DIM_W)
  ) u_gradient (
    .col(col_r),
    .row(row_r),
    .fcnt(fcnt_r),
    .sel(frame_sel_r),
    .value(gen_val)
  );

  // Output stream: generated pixels in test mode, sensor otherwise.
  // No gain or offset sits on the generated path, so analog settings
  // cannot reach it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pix_valid_r <= 1'b0;
      pix_data_r <= '0;
      pix_sol_r <= 1'b0;
      pix_sof_r <= 1'b0;
      pix_eol_r <= 1'b0;
      pix_eof_r <= 1'b0;
      pix_test_r <= 1'b0;
    end else if (test_mode) begin
      pix_valid_r <= (st_r == ST_LINE); // RULE1
      pix_data_r <= gen_val; // RULE1 RULE5
      pix_sol_r <= (st_r == ST_LINE) && (col_r == '0);
      pix_sof_r <= (st_r == ST_LINE) && (col_r == '0) && (row_r == '0);
      pix_eol_r <= (st_r == ST_LINE) && last_col;
      pix_eof_r <= (st_r == ST_LINE) && last_col && last_row;
      pix_test_r <= 1'b1;
    end else begin
      pix_valid_r <= sens_valid;
      pix_data_r <= sens_data;
      pix_sol_r <= sens_sol;
      pix_sof_r <= sens_sof;
      pix_eol_r <= sens_eol;
      pix_eof_r <= sens_eof;
      pix_test_r <= 1'b0;
    end
  end

  // Processing bypass for the first three patterns only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pix_bypass_r <= 1'b0;
    end else if (test_mode) begin
      pix_bypass_r <= (gen_busy ? frame_sel_r : sel_r) inside {PATTERN_SELECT_FIRST,
                      PATTERN_SELECT_MOV8, PATTERN_SELECT_MOV12}; // RULE6 RULE12 RULE13
    end else begin
      pix_bypass_r <= 1'b0;
    end
  end

  // Frame end hands off to transmission just as a sensor frame does
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_done_r <= 1'b0;
    end else if (test_mode) begin
      frame_done_r <= (st_r == ST_LINE) && last_col && last_row; // RULE2
    end else begin
      frame_done_r <= sens_valid && sens_eof; // RULE2
    end
  end

  // Port drive
  assign s_axi_awready = aw_ready_r;
  assign s_axi_wready = w_ready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ar_ready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pix_valid = pix_valid_r;
  assign pix_data = pix_data_r;
  assign pix_sol = pix_sol_r;
  assign pix_sof = pix_sof_r;
  assign pix_eol = pix_eol_r;
  assign pix_eof = pix_eof_r;
  assign pix_bypass = pix_bypass_r;
  assign pix_test = pix_test_r;
  assign frame_done = frame_done_r;

endmodule

`default_nettype wire

// ---- sim/tpg_sva.sv ----
// Handshake and stream checker for the test pattern generator
`timescale 1ns/1ps
`default_nettype none
module tpg_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Streams
  input wire logic sens_valid,
  input wire logic sens_eof,
  input wire logic pix_valid,
  input wire logic pix_sol,
  input wire logic pix_sof,
  input wire logic pix_eol,
  input wire logic pix_eof,
  input wire logic pix_test,
  input wire logic frame_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Write steps: both halves taken, one quiet cycle, then the answer
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_resp_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_wr_resp: assert property (s_wr_both |=> s_resp_late)
    else $error("write response not two cycles after request");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_rd_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_sof_first: assert property (pix_sof |-> pix_valid && pix_sol)
    else $error("frame start not on a line start pixel");
  a_eol_valid: assert property (pix_eol |-> pix_valid)
    else $error("line end without a pixel");
  a_test_done: assert property (pix_test && pix_eof |-> frame_done)
    else $error("generated frame end without frame done");
  a_norm_done: assert property (!pix_test && sens_valid && sens_eof |=> frame_done)
    else $error("sensor frame end without frame done");
  a_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame done longer than one cycle");
endmodule
`default_nettype wire

// ---- sim/tpg_sink.sv ----
// Downstream consumer model that records each generated frame
`timescale 1ns/1ps
`default_nettype none
module tpg_sink
  import tpg_pkg::*;
(
  // Clock
  input wire logic clk,
  // Pixel stream
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_data,
  input wire logic pix_sol,
  input wire logic pix_sof,
  input wire logic pix_bypass,
  input wire logic pix_test
);
  logic [PIX_W-1:0] mem [0:63];
  int col, row, frames, npix;
  logic byp;
  // No backpressure exists, so every valid pixel is stored
  always @(posedge clk) begin
    if (pix_valid) begin
      if (pix_sof) begin
        row = 0;
        npix = 0;
        byp = pix_bypass;
        if (pix_test) frames++;
      end else if (pix_sol) row++;
      if (pix_sol) col = 0;
      mem[row*8+col] = pix_data;
      col++;
      npix++;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the test pattern generator
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tpg_pkg::*;
  logic clk = 0, reset_n = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic frame_trig_pin = 0, line_trig_pin = 0;
  logic sens_valid = 0, sens_sol = 0, sens_sof = 0, sens_eol = 0, sens_eof = 0;
  logic [PIX_W-1:0] sens_data = 0, pix_data;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pix_valid, pix_sol, pix_sof, pix_eol, pix_eof, pix_bypass, pix_test, frame_done;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int failures = 0, total_checks = 0, cyc = 0, base;

  always #4 clk = ~clk;
  tpg_top i_dut (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .frame_trig_pin(frame_trig_pin), .line_trig_pin(line_trig_pin),
    .sens_valid(sens_valid), .sens_data(sens_data), .sens_sol(sens_sol), .sens_sof(sens_sof),
    .sens_eol(sens_eol), .sens_eof(sens_eof),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_sol(pix_sol), .pix_sof(pix_sof),
    .pix_eol(pix_eol), .pix_eof(pix_eof), .pix_bypass(pix_bypass), .pix_test(pix_test),
    .frame_done(frame_done)
  );
  tpg_sink i_sink (
    .clk(clk), .pix_valid(pix_valid), .pix_data(pix_data), .pix_sol(pix_sol),
    .pix_sof(pix_sof), .pix_bypass(pix_bypass), .pix_test(pix_test)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    do begin
      @(posedge clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                    input logic [31:0] m = 32'hffffffff);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do begin
      @(posedge clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rdata", exp, s_axi_rdata & m);
    chk("rresp", er, s_axi_rresp);
  endtask

  // The sink takes the last pixel one edge after the pulse, so wait past it
  task automatic wait_fd;
    do @(negedge clk); while (!frame_done);
    @(negedge clk);
  endtask

  // Frame of 3 by 2 against the gradient formula
  task automatic chk_frame(input int p);
    int k;
    k = (p == 1) ? 0 : i_sink.frames;
    for (int r = 0; r < 2; r++)
      for (int c = 0; c < 3; c++)
        chk("pixel", (c + r + k) & ((p == 3 || p == 5) ? 32'hfff : 32'hff), i_sink.mem[r*8+c]);
    chk("bypass", p <= 3, i_sink.byp);
    chk("pixel count", 6, i_sink.npix);
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(REG_WIDTH, 32'h800, RESP_OKAY);
    rd(REG_HEIGHT, 32'h400, RESP_OKAY);
    rd(REG_STATUS, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_DECERR);
    wr(8'h14, 32'h1, RESP_DECERR);
    wr(REG_WIDTH, 32'h0, RESP_OKAY);
    rd(REG_WIDTH, 32'h1, RESP_OKAY);
    wr(REG_WIDTH, 32'h3, RESP_OKAY);
    wr(REG_HEIGHT, 32'h2, RESP_OKAY);
    $display("register test done");
    // Sensor keeps streaming junk, which must not show
    sens_valid <= 1'b1;
    sens_data <= 12'habc;
    for (int p = 1; p <= 5; p++) begin
      wr(REG_CTRL, 32'h10 | p, RESP_OKAY);
      wait_fd;
      // Pattern 2 runs until the counter carries the gradient past 255
      do wait_fd; while (p == 2 && i_sink.frames < 254);
      chk_frame(p);
    end
    $display("pattern test done");
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    repeat (20) @(posedge clk);
    sens_sof <= 1'b1;
    sens_sol <= 1'b1;
    sens_eol <= 1'b1;
    sens_eof <= 1'b1;
    sens_data <= 12'h5a5;
    @(posedge clk);
    sens_valid <= 1'b0;
    sens_sof <= 1'b0;
    sens_sol <= 1'b0;
    sens_eol <= 1'b0;
    sens_eof <= 1'b0;
    @(negedge clk);
    chk("pass data", 12'h5a5, pix_data);
    chk("pass sol", 1'b1, pix_sol);
    chk("pass eof", 1'b1, pix_eof);
    chk("test flag", 1'b0, pix_test);
    $display("sensor test done");
    wr(REG_CTRL, 32'h19, RESP_OKAY);
    base = i_sink.frames;
    repeat (30) @(posedge clk);
    chk("no trigger", base, i_sink.frames);
    // Far side supplies frame and line triggers
    frame_trig_pin <= 1'b1;
    repeat (2) @(posedge clk);
    frame_trig_pin <= 1'b0;
    repeat (2) begin
      repeat (8) @(posedge clk);
      line_trig_pin <= 1'b1;
      repeat (2) @(posedge clk);
      line_trig_pin <= 1'b0;
    end
    wait_fd;
    chk("ext frames", base + 1, i_sink.frames);
    chk_frame(1);
    rd(REG_STATUS, base + 1, RESP_OKAY, 32'hfff);
    $display("trigger test done");
    test_done;
  end
endmodule

bind tpg_top tpg_sva u_sva (
  .clk(clk), .reset_n(reset_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .sens_valid(sens_valid), .sens_eof(sens_eof),
  .pix_valid(pix_valid), .pix_sol(pix_sol), .pix_sof(pix_sof), .pix_eol(pix_eol),
  .pix_eof(pix_eof), .pix_test(pix_test), .frame_done(frame_done)
);
`default_nettype wire
